// >>> rtl/hmh_pkg.sv
/*
  Package for the host MAC station address, group filter and PHY access
  block: register indices, field positions, reset values and carriers.
  Assumes a plain register port with word indices as addresses.
*/
package hmh_pkg;

  // ---------------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------------
  localparam logic [3:0] ADDR_HIGH_IDX = 4'h2;
  localparam logic [3:0] ADDR_LOW_IDX = 4'h3;
  localparam logic [3:0] FILT_HIGH_IDX = 4'h4;
  localparam logic [3:0] FILT_LOW_IDX = 4'h5;
  localparam logic [3:0] MGMT_ACC_IDX = 4'h6;
  localparam logic [3:0] MGMT_DATA_IDX = 4'h7;
  localparam logic [3:0] MAC_CTRL_IDX = 4'h8;
  localparam int REG_ADDR_W = 6;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [15:0] ADDR_HIGH_RST = 16'hffff;
  localparam logic [31:0] ADDR_LOW_RST = 32'h0fffffff;
  localparam logic [31:0] FILT_RST = 32'h00000000;
  localparam logic [15:0] MGMT_DATA_RST = 16'h0000;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int PHY_SEL_LSB = 11;
  localparam int PHY_IDX_LSB = 6;
  localparam int WRITE_SEL_BIT = 1;
  localparam int PENDING_BIT = 0;
  localparam int ACCEPT_ALL_BIT = 0;

  // ---------------------------------------------------------------------
  // Non-volatile store byte addresses of the station address
  // ---------------------------------------------------------------------
  localparam logic [7:0] NV_LOW_BYTE0 = 8'h01;
  localparam logic [7:0] NV_HIGH_BYTE0 = 8'h05;
  localparam logic [7:0] NV_HIGH_BYTE1 = 8'h06;

  // ---------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [REG_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } hmh_bus_req_type;

  typedef struct packed {
    logic [4:0] phy_select;
    logic [4:0] phy_reg_index;
    logic write;
    logic [15:0] wdata;
  } hmh_phy_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } hmh_nv_byte_type;

endpackage : hmh_pkg

// >>> rtl/hmh_group_filter.sv
/*
  Group address filter: turns a six bit hash index into an accept
  decision. Assumes the index is already computed from the destination
  address upstream.
*/
`timescale 1ns/10ps
`default_nettype none

module hmh_group_filter (
  input wire logic [31:0] filter_high,
  input wire logic [31:0] filter_low,
  input wire logic accept_all_group,
  input wire logic [5:0] hash_index,
  output logic accept
);

  logic [63:0] table_bits;

  // ---------------------------------------------------------------------
  // Lookup
  // ---------------------------------------------------------------------
  // Top index bit picks the high word, the other five the bit.
  assign table_bits = {filter_high, filter_low};
  assign accept = accept_all_group | table_bits[hash_index];

endmodule : hmh_group_filter

`default_nettype wire

// >>> rtl/hmh_phy_access.sv
/*
  PHY management sequencer: issues one access to the internal PHY
  registers and reports when it has finished. Assumes the PHY side
  answers each request with a one cycle done pulse.
*/
`timescale 1ns/10ps
`default_nettype none

module hmh_phy_access (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire hmh_pkg::hmh_phy_req_type req,
  output hmh_pkg::hmh_phy_req_type phy_req,
  output logic phy_req_valid,
  input wire logic phy_done,
  input wire logic [15:0] phy_rdata,
  output logic pending,
  output logic rd_done,
  output logic [15:0] rd_data
);

  typedef enum logic [1:0] {
    hmh_idle,
    hmh_issue,
    hmh_wait
  } hmh_state_type;

  hmh_state_type state;

  // ---------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= hmh_idle;
    end else begin
      case (state)
        hmh_idle: begin
          if (start) begin
            state <= hmh_issue;
          end
        end
        hmh_issue: begin
          state <= hmh_wait;
        end
        hmh_wait: begin
          if (phy_done) begin
            state <= hmh_idle;
          end
        end
        default: begin
          state <= hmh_idle;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phy_req <= '0;
    end else if (start && state == hmh_idle) begin
      phy_req <= req;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_done <= 1'b0;
      rd_data <= 16'h0000;
    end else begin
      rd_done <= (state == hmh_wait) && phy_done && !phy_req.write;
      if (state == hmh_wait && phy_done && !phy_req.write) begin
        rd_data <= phy_rdata;
      end
    end
  end

  assign phy_req_valid = (state == hmh_issue);
  // Busy follows the sequencer state alone. Folding start in would loop
  // back through the start decode, which itself waits for busy low.
  assign pending = (state != hmh_idle);

endmodule : hmh_phy_access

`default_nettype wire

// >>> rtl/hmh_top.sv
/*
  Host MAC station address, group filter and PHY management access
  registers. Assumes a plain register port with read data one cycle
  after the read strobe, a loader that presents non-volatile bytes at
  power-on, and a PHY management side that pulses done per access.
*/
// Our own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Address bits 47:32 in high register low half
// - Loader fills high bytes from 05h, 06h
// - Loader fills low register from bytes 01h-04h
// - Load only with programmed store, else reset values ffffh high, 0fffffffh low
// - Six hash bits index 64-bit filter
// - Index 0 low bit 0, 63 high bit 31
// - Accept when selected filter bit is one
// - Accept-all flag passes every group frame
// - Decision applies to frames from switch fabric
// - Bits 10:6 index the PHY register
// - Bit 1 selects write, else read
// - Pending reads one, clears itself at completion
// - Data register index 7, low sixteen bits
module hmh_top (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic nv_present,
  input wire logic nv_byte_valid,
  input wire logic [7:0] nv_byte_addr,
  input wire logic [7:0] nv_byte_data,
  input wire logic init_done,
  input wire logic fabric_frame_valid,
  input wire logic fabric_frame_group,
  input wire logic [5:0] fabric_hash_index,
  output logic frame_accept,
  output logic frame_reject,
  output hmh_pkg::hmh_phy_req_type phy_req,
  output logic phy_req_valid,
  input wire logic phy_done,
  input wire logic [15:0] phy_rdata
);

  hmh_pkg::hmh_bus_req_type bus;
  hmh_pkg::hmh_nv_byte_type nv;
  hmh_pkg::hmh_phy_req_type acc_req;
  logic [15:0] addr_high;
  logic [31:0] addr_low;
  logic [31:0] filter_high;
  logic [31:0] filter_low;
  logic accept_all_group;
  logic [4:0] phy_select;
  logic [4:0] phy_reg_index;
  logic phy_write_select;
  logic [15:0] phy_mgmt_data;
  logic start;
  logic pending;
  logic rd_done;
  logic [15:0] rd_data;
  logic filter_hit;
  logic load_en;
  logic [7:0] low_off;
  logic [31:0] next_rdata;

  // ---------------------------------------------------------------------
  // Bus and loader carriers
  // ---------------------------------------------------------------------
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign nv = '{valid: nv_byte_valid, addr: nv_byte_addr,
                data: nv_byte_data};

  // The loader only writes while a programmed store is present and
  // the initialisation sequence is still running.
  assign load_en = nv.valid && nv_present && !init_done;
  assign low_off = nv.addr - hmh_pkg::NV_LOW_BYTE0;

  function automatic logic wr_hit(input hmh_pkg::hmh_bus_req_type b,
                                  input logic [3:0] idx);
    wr_hit = b.wr && (b.addr == {2'b00, idx});
  endfunction : wr_hit

  // ---------------------------------------------------------------------
  // Station address
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_high <= hmh_pkg::ADDR_HIGH_RST;
    end else if (load_en && nv.addr == hmh_pkg::NV_HIGH_BYTE0) begin
      addr_high[7:0] <= nv.data;
    end else if (load_en && nv.addr == hmh_pkg::NV_HIGH_BYTE1) begin
      addr_high[15:8] <= nv.data;
    end else if (wr_hit(bus, hmh_pkg::ADDR_HIGH_IDX)) begin
      addr_high <= bus.wdata[15:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_low <= hmh_pkg::ADDR_LOW_RST;
    end else if (load_en && low_off < 8'h04) begin
      addr_low[low_off[1:0]*8 +: 8] <= nv.data;
    end else if (wr_hit(bus, hmh_pkg::ADDR_LOW_IDX)) begin
      addr_low <= bus.wdata;
    end
  end

  // ---------------------------------------------------------------------
  // Group filter words and control
  // ---------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      filter_high <= hmh_pkg::FILT_RST;
      filter_low <= hmh_pkg::FILT_RST;
    end else begin
      if (wr_hit(bus, hmh_pkg::FILT_HIGH_IDX)) begin
        filter_high <= bus.wdata;
      end
      if (wr_hit(bus, hmh_pkg::FILT_LOW_IDX)) begin
        filter_low <= bus.wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      accept_all_group <= 1'b0;
    end else if (wr_hit(bus, hmh_pkg::MAC_CTRL_IDX)) begin
      accept_all_group <= bus.wdata[hmh_pkg::ACCEPT_ALL_BIT];
    end
  end

  hmh_group_filter u_filter (
    .filter_high(filter_high),
    .filter_low(filter_low),
    .accept_all_group(accept_all_group),
    .hash_index(fabric_hash_index),
    .accept(filter_hit)
  );

  // Only group frames from the fabric are judged here; other frames
  // pass through untouched by this decision.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_accept <= 1'b0;
      frame_reject <= 1'b0;
    end else begin
      frame_accept <= fabric_frame_valid &&
                      (!fabric_frame_group || filter_hit);
      frame_reject <= fabric_frame_valid &&
                      fabric_frame_group && !filter_hit;
    end
  end

  // ---------------------------------------------------------------------
  // PHY management access
  // ---------------------------------------------------------------------
  // Writes during a pending access are dropped to protect the data.
  assign start = wr_hit(bus, hmh_pkg::MGMT_ACC_IDX) && !pending &&
                 bus.wdata[hmh_pkg::PENDING_BIT];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phy_select <= 5'h00;
      phy_reg_index <= 5'h00;
      phy_write_select <= 1'b0;
    end else if (wr_hit(bus, hmh_pkg::MGMT_ACC_IDX) && !pending) begin
      phy_select <= bus.wdata[hmh_pkg::PHY_SEL_LSB +: 5];
      phy_reg_index <= bus.wdata[hmh_pkg::PHY_IDX_LSB +: 5];
      phy_write_select <= bus.wdata[hmh_pkg::WRITE_SEL_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phy_mgmt_data <= hmh_pkg::MGMT_DATA_RST;
    end else if (rd_done) begin
      phy_mgmt_data <= rd_data;
    end else if (wr_hit(bus, hmh_pkg::MGMT_DATA_IDX) && !pending) begin
      phy_mgmt_data <= bus.wdata[15:0];
    end
  end

  assign acc_req = '{phy_select: bus.wdata[hmh_pkg::PHY_SEL_LSB +: 5],
                     phy_reg_index: bus.wdata[hmh_pkg::PHY_IDX_LSB +: 5],
                     write: bus.wdata[hmh_pkg::WRITE_SEL_BIT],
                     wdata: phy_mgmt_data};

  hmh_phy_access u_access (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .start(start),
    .req(acc_req),
    .phy_req(phy_req),
    .phy_req_valid(phy_req_valid),
    .phy_done(phy_done),
    .phy_rdata(phy_rdata),
    .pending(pending),
    .rd_done(rd_done),
    .rd_data(rd_data)
  );

  // ---------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h00000000;
    case (bus.addr)
      {2'b00, hmh_pkg::ADDR_HIGH_IDX}: next_rdata = {16'h0000, addr_high};
      {2'b00, hmh_pkg::ADDR_LOW_IDX}: next_rdata = addr_low;
      {2'b00, hmh_pkg::FILT_HIGH_IDX}: next_rdata = filter_high;
      {2'b00, hmh_pkg::FILT_LOW_IDX}: next_rdata = filter_low;
      {2'b00, hmh_pkg::MGMT_ACC_IDX}: begin
        next_rdata = {16'h0000, phy_select, phy_reg_index, 4'h0,
                      phy_write_select, pending};
      end
      {2'b00, hmh_pkg::MGMT_DATA_IDX}: begin
        next_rdata = {16'h0000, phy_mgmt_data};
      end
      {2'b00, hmh_pkg::MAC_CTRL_IDX}: begin
        next_rdata = {31'h00000000, accept_all_group};
      end
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (bus.rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule : hmh_top

`default_nettype wire

// >>> bench/hmh_checker.sv
/* Port checker for hmh_top.
   Assumes it is bound onto hmh_top and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module hmh_checker (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [5:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic fabric_frame_valid,
  input wire logic fabric_frame_group,
  input wire logic frame_accept,
  input wire logic frame_reject,
  input wire hmh_pkg::hmh_phy_req_type phy_req,
  input wire logic phy_req_valid,
  input wire logic phy_done
);
  // ----------------
  // Access tracking
  // ----------------
  // Mirrors the pending bit so that refused starts can be told apart.
  logic busy_q;
  logic start;
  assign start = reg_wr && reg_addr == 6'h06 && reg_wdata[0] && !busy_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else if (start) begin
      busy_q <= 1'b1;
    end else if (phy_done) begin
      busy_q <= 1'b0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence group_frame_s;
    fabric_frame_valid && fabric_frame_group;
  endsequence
  sequence idle_poll_s;
    reg_rd && reg_addr == 6'h06 && !busy_q;
  endsequence
  launch_fields_a: assert property (start |=> phy_req_valid
    && phy_req.phy_select == $past(reg_wdata[15:11])
    && phy_req.phy_reg_index == $past(reg_wdata[10:6])
    && phy_req.write == $past(reg_wdata[1]))
    else $error("PHY request fields differ from access write");
  launch_cause_a: assert property (phy_req_valid |-> $past(start))
    else $error("PHY request without an accepted start");
  req_hold_a: assert property (
    busy_q && !phy_req_valid |-> $stable(phy_req))
    else $error("PHY request changed while pending");
  busy_read_a: assert property (
    reg_rd && reg_addr == 6'h06 && busy_q && !phy_done |=> reg_rdata[0])
    else $error("Pending bit reads zero during access");
  self_clear_a: assert property (idle_poll_s |=> !reg_rdata[0])
    else $error("Pending bit still set after completion");
  reserved_zero_a: assert property (
    reg_rd && reg_addr inside {6'h02, 6'h06, 6'h07}
    |=> reg_rdata[31:16] == 16'h0000)
    else $error("Reserved upper half reads nonzero");
  unmapped_zero_a: assert property (
    reg_rd && (reg_addr < 6'h02 || reg_addr > 6'h08) |=> reg_rdata == 0)
    else $error("Unmapped index reads nonzero");
  frame_judge_a: assert property (
    group_frame_s |=> frame_accept != frame_reject)
    else $error("Group frame not judged exactly once");
  plain_accept_a: assert property (
    fabric_frame_valid && !fabric_frame_group |=> frame_accept)
    else $error("Non-group frame not accepted");
endmodule : hmh_checker
bind hmh_top hmh_checker u_hmh_checker (
  .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .fabric_frame_valid(fabric_frame_valid),
  .fabric_frame_group(fabric_frame_group), .frame_accept(frame_accept),
  .frame_reject(frame_reject), .phy_req(phy_req),
  .phy_req_valid(phy_req_valid), .phy_done(phy_done));
`default_nettype wire

// >>> bench/hmh_phy_model.sv
/* Behavioural internal PHY management side.
   Assumes one request pulse per access; lat of at least one. */
`timescale 1ns/10ps
`default_nettype none
module hmh_phy_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] lat,
  input wire hmh_pkg::hmh_phy_req_type phy_req,
  input wire logic phy_req_valid,
  output logic phy_done,
  output logic [15:0] phy_rdata
);
  hmh_pkg::hmh_phy_req_type req_q;
  logic [3:0] cnt;
  logic [15:0] last;
  logic [9:0] key;
  logic [15:0] val;
  // Outside the done pulse the data is junk, so show the inverse.
  assign phy_rdata = phy_done ? last : ~last;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 4'h0;
      phy_done <= 1'b0;
      last <= 16'h0000;
      req_q <= '0;
      key <= 10'h3ff;
      val <= 16'h0000;
    end else begin
      phy_done <= 1'b0;
      if (phy_req_valid) begin
        req_q <= phy_req;
        cnt <= lat;
      end else if (cnt == 4'h1) begin
        cnt <= 4'h0;
        phy_done <= 1'b1;
        if (req_q.write) begin
          key <= {req_q.phy_select, req_q.phy_reg_index};
          val <= req_q.wdata;
        end else if (key == {req_q.phy_select, req_q.phy_reg_index}) begin
          last <= val;
        end else begin
          last <= {6'h28, req_q.phy_select, req_q.phy_reg_index};
        end
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : hmh_phy_model
`default_nettype wire

// >>> bench/tb.sv
/* Self-checking bench for hmh_top.
   Assumes hmh_checker is bound and hmh_phy_model answers the PHY side. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic core_clk;
  logic rst_b;
  logic [5:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic reg_wr, reg_rd, nv_present, nv_byte_valid, init_done;
  logic [7:0] nv_byte_addr, nv_byte_data;
  logic fabric_frame_valid, fabric_frame_group;
  logic [5:0] fabric_hash_index;
  logic frame_accept, frame_reject, phy_req_valid, phy_done;
  hmh_pkg::hmh_phy_req_type phy_req;
  logic [15:0] phy_rdata;
  logic [3:0] lat;
  int bad_count;
  int tests_run;
  localparam logic [5:0] RA [0:7] = '{6'h02, 6'h03, 6'h04, 6'h05,
    6'h06, 6'h07, 6'h08, 6'h3f};
  localparam logic [31:0] RV [0:7] = '{32'h0000ffff, 32'h0fffffff,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  localparam logic [5:0] FI [0:4] = '{6'h00, 6'h3f, 6'h01, 6'h20, 6'h1f};
  localparam logic [1:0] FE [0:4] = '{2'b10, 2'b10, 2'b01, 2'b01, 2'b01};
  hmh_top u_hmh_top (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nv_present(nv_present),
    .nv_byte_valid(nv_byte_valid), .nv_byte_addr(nv_byte_addr),
    .nv_byte_data(nv_byte_data), .init_done(init_done),
    .fabric_frame_valid(fabric_frame_valid),
    .fabric_frame_group(fabric_frame_group),
    .fabric_hash_index(fabric_hash_index), .frame_accept(frame_accept),
    .frame_reject(frame_reject), .phy_req(phy_req),
    .phy_req_valid(phy_req_valid), .phy_done(phy_done),
    .phy_rdata(phy_rdata));
  hmh_phy_model u_hmh_phy_model (.core_clk(core_clk), .rst_b(rst_b),
    .lat(lat), .phy_req(phy_req), .phy_req_valid(phy_req_valid),
    .phy_done(phy_done), .phy_rdata(phy_rdata));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ----------------
  // Access tasks
  // ----------------
  function automatic logic [31:0] acc(input logic [4:0] s,
    input logic [4:0] i, input logic w, input logic b);
    return {16'h0, s, i, 4'h0, w, b};
  endfunction : acc
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(d, exp);
  endtask : rdc
  task automatic wait_idle;
    logic [31:0] d;
    for (int n = 0; n < 40; n++) begin
      rd(6'h06, d);
      if (d[0] === 1'b0) return;
    end
    bad_count++;
    complete_run;
  endtask : wait_idle
  task automatic nv(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    nv_byte_valid <= 1'b1;
    nv_byte_addr <= a;
    nv_byte_data <= d;
    @(posedge core_clk);
    nv_byte_valid <= 1'b0;
  endtask : nv
  task automatic frame(input logic [5:0] i, input logic g,
    input logic [1:0] exp);
    @(posedge core_clk);
    fabric_frame_valid <= 1'b1;
    fabric_frame_group <= g;
    fabric_hash_index <= i;
    @(posedge core_clk);
    fabric_frame_valid <= 1'b0;
    #1 check({30'h0, frame_accept, frame_reject}, {30'h0, exp});
  endtask : frame
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    complete_run;
  end
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, nv_present, nv_byte_valid} = '0;
    {init_done, nv_byte_addr, nv_byte_data, fabric_frame_valid} = '0;
    {fabric_frame_group, fabric_hash_index} = '0;
    lat = 4'h1;
    rst_b = 1'b0;
    bad_count = 0;
    tests_run = 0;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 8; i++) rdc(RA[i], RV[i]);
    $display("reset values done");
    nv(8'h05, 8'h99);
    rdc(6'h02, 32'h0000ffff);
    nv_present <= 1'b1;
    for (int i = 1; i < 8; i++) nv(8'(i), 8'(i * 17));
    init_done <= 1'b1;
    nv(8'h01, 8'hee);
    rdc(6'h03, 32'h44332211);
    rdc(6'h02, 32'h00006655);
    wr(6'h02, 32'hdeadbeef);
    rdc(6'h02, 32'h0000beef);
    wr(6'h03, 32'h12345678);
    rdc(6'h03, 32'h12345678);
    $display("station address done");
    wr(6'h05, 32'h00000001);
    wr(6'h04, 32'h80000000);
    for (int i = 0; i < 5; i++) frame(FI[i], 1'b1, FE[i]);
    frame(6'h01, 1'b0, 2'b10);
    wr(6'h08, 32'h00000001);
    frame(6'h01, 1'b1, 2'b10);
    $display("group filter done");
    lat <= 4'hf;
    wr(6'h07, 32'h0000a5c3);
    wr(6'h06, acc(5'd1, 5'd2, 1'b1, 1'b1));
    rdc(6'h06, acc(5'd1, 5'd2, 1'b1, 1'b1));
    wr(6'h07, 32'h00001111);
    rdc(6'h07, 32'h0000a5c3);
    wait_idle;
    rdc(6'h06, acc(5'd1, 5'd2, 1'b1, 1'b0));
    $display("phy write done");
    lat <= 4'h1;
    wr(6'h07, 32'h00000000);
    wr(6'h06, acc(5'd1, 5'd2, 1'b0, 1'b1));
    wait_idle;
    rdc(6'h07, 32'h0000a5c3);
    wr(6'h06, acc(5'd3, 5'd5, 1'b0, 1'b1));
    wait_idle;
    rdc(6'h07, {16'h0, 6'h28, 5'd3, 5'd5});
    $display("phy read done");
    complete_run;
  end
endmodule : tb
`default_nettype wire
